/* logic/serial_line_ctrl.sv */
// Functional notes
// - DTR on drives high always, off drives low always.
// - DTR tracking mode follows receive buffer readiness.
// - DTR tracking without RS422: transmitter waits while partner holds DSR low.
// - DTR mode survives reset.
// - DTR change in a write that also sets RS422 refused with -221.
// - RTS on drives high always, off drives low always.
// - RTS tracking mode follows receive buffer readiness.
// - RTS tracking: transmitter waits while partner holds CTS low.
// - One shared baud setting from listed rates, default 9600.
// - Unlisted baud refused with -224, old rate kept.
// - One shared word length, seven or eight bits.
// - Other word lengths refused with -224.
// - Baud, length, pacing and parity survive reset.
// - Receive pacing sends Xon when ready, Xoff when buffer fills.
// - Even parity generated and checked, mismatch flagged.
// - Odd parity generated and checked, mismatch flagged.
// - Stick-zero parity sent low, non-low received flagged.
// - Stick-one parity sent high, non-high received flagged.
// - No parity: none sent, none expected.
// - One parity setting serves transmit and receive.
// - One or two stop bits, shared by both directions.
// - Transmit pacing: Xoff from partner stops data until Xon.
// - Stop bit count survives reset.
`default_nettype none
module serial_line_ctrl
	import serial_line_pkg::*;
#(
	parameter int unsigned CLK_HZ = SYS_CLK_HZ
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_por,
	input wire logic i_clk_en,
	input wire apb_req_t i_apb,
	output var apb_rsp_t o_apb,
	input wire logic i_rxd,
	input wire logic i_cts,
	input wire logic i_dsr,
	output logic o_txd,
	output logic o_dtr,
	output logic o_rts
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [1:0] dtr_mode;
		logic [1:0] rts_mode;
		logic rs422;
		logic [4:0] baud_sel;
		logic word8;
		logic [2:0] parity;
		logic stop2;
		logic rx_software_pacing_enable;
		logic tx_software_pacing_enable;
		logic [1:0] rxd_s;
		logic [1:0] cts_s;
		logic [1:0] dsr_s;
		logic dtr;
		logic rts;
		tx_state_t tx_st;
		logic [19:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		logic tx_pbit;
		logic txd;
		logic [7:0] hold;
		logic hold_v;
		logic flow_pend;
		logic flow_xon;
		logic ready_q;
		logic paused;
		rx_state_t rx_st;
		logic [19:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_pbad;
		logic [7:0] rx_buf;
		logic rx_full;
		logic par_err;
		logic [15:0] err_code;
		logic err_pend;
		logic armed;
		logic [31:0] rdata;
		logic slverr;
	} st_t;

	st_t s;
	st_t n;

	////////////////////////////////////////////////////////////////////////////
	// Bit period in clocks for a rate index
	function automatic logic [19:0] bit_div(input logic [4:0] sel);
		logic [19:0] d;
		d = 20'(CLK_HZ / BAUD_LIST[0]);
		for (int i = 0; i < BAUD_N; i++) begin
			if (sel == 5'(i)) begin
				d = 20'(CLK_HZ / BAUD_LIST[i]);
			end
		end
		return d;
	endfunction

	// Rate index for a numeric rate, or the bad marker
	function automatic logic [4:0] baud_find(input logic [16:0] r);
		logic [4:0] k;
		k = BAUD_BAD;
		for (int i = 0; i < BAUD_N; i++) begin
			if (r == 17'(BAUD_LIST[i])) begin
				k = 5'(i);
			end
		end
		return k;
	endfunction

	// Numeric rate for a rate index
	function automatic logic [16:0] baud_val(input logic [4:0] sel);
		logic [16:0] v;
		v = 17'(BAUD_LIST[0]);
		for (int i = 0; i < BAUD_N; i++) begin
			if (sel == 5'(i)) begin
				v = 17'(BAUD_LIST[i]);
			end
		end
		return v;
	endfunction

	// Parity bit for a character under a parity type
	function automatic logic par_bit(input logic [2:0] ptype, input logic [7:0] d,
		input logic w8);
		logic x;
		x = w8 ? ^d : ^d[6:0];
		unique case (ptype)
			PAR_EVEN: par_bit = x;
			PAR_ODD: par_bit = ~x;
			PAR_ZERO: par_bit = 1'b0;
			PAR_ONE: par_bit = 1'b1;
			default: par_bit = 1'b0;
		endcase
	endfunction

	// Modem line level for a mode
	function automatic logic mode_level(input logic [1:0] mode, input logic ready);
		unique case (mode)
			MODE_ON: mode_level = 1'b1;
			MODE_TRACK: mode_level = ready;
			default: mode_level = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [19:0] div;
	logic [2:0] last_bit;
	logic rxd;
	logic cts;
	logic dsr;
	logic can_accept;
	logic hw_ok;
	logic take;
	logic err_set;
	logic [15:0] err_val;
	logic [7:0] rx_word;
	logic tx_tick;
	logic rx_tick;
	logic tx_load;
	logic [7:0] tx_word;
	modem_reg_t wm;
	baud_reg_t wb;
	format_reg_t wf;
	logic [4:0] bidx;
	logic [31:0] rmux;
	logic rbad;

	// Next-state logic
	always_comb begin
		n = s;
		div = bit_div(s.baud_sel);
		last_bit = s.word8 ? 3'h7 : 3'h6;
		rxd = s.rxd_s[1];
		cts = s.cts_s[1];
		dsr = s.dsr_s[1];
		can_accept = ~s.rx_full;
		hw_ok = (s.rts_mode != MODE_TRACK || cts)
			&& (s.rs422 || s.dtr_mode != MODE_TRACK || dsr);
		take = i_apb.psel & i_apb.penable & s.armed;
		err_set = 1'b0;
		err_val = ERR_NONE;
		wm = modem_reg_t'(i_apb.pwdata);
		wb = baud_reg_t'(i_apb.pwdata);
		wf = format_reg_t'(i_apb.pwdata);
		bidx = baud_find(wb.rate);
		rx_word = s.word8 ? s.rx_sh : {1'b0, s.rx_sh[7:1]};
		tx_tick = (s.tx_cnt == 20'h0);
		rx_tick = (s.rx_cnt == 20'h0);
		tx_load = 1'b0;
		tx_word = s.hold;
		rmux = 32'h0;
		rbad = 1'b0;

		// Two-flop synchronisers
		n.rxd_s = {s.rxd_s[0], i_rxd};
		n.cts_s = {s.cts_s[0], i_cts};
		n.dsr_s = {s.dsr_s[0], i_dsr};

		// Modem outputs
		n.dtr = mode_level(s.dtr_mode, can_accept);
		n.rts = mode_level(s.rts_mode, can_accept);

		// Read mux, captured in the setup cycle
		unique case (i_apb.paddr)
			ADDR_MODEM: rmux = 32'(modem_reg_t'{rsvd: '0, rs422: s.rs422,
				rts: s.rts_mode, dtr: s.dtr_mode});
			ADDR_BAUD: rmux = 32'(baud_reg_t'{rsvd: '0, rate: baud_val(s.baud_sel)});
			ADDR_FORMAT: rmux = 32'(format_reg_t'{rsvd: '0, tx_software_pacing_enable: s.tx_software_pacing_enable,
				rx_software_pacing_enable: s.rx_software_pacing_enable, stop: s.stop2 ? STOP_2 : STOP_1, pad: 1'b0,
				parity: s.parity, wlen: s.word8 ? WLEN_8 : WLEN_7});
			ADDR_TXDATA: rmux = 32'h0;
			ADDR_RXDATA: rmux = 32'(rxdata_reg_t'{rsvd: '0, valid: s.rx_full,
				par_err: s.par_err, data: s.rx_buf});
			ADDR_STATUS: rmux = 32'(status_reg_t'{rsvd: '0, hw_block: ~hw_ok,
				paused: s.paused, dsr: dsr, cts: cts, rx_full: s.rx_full,
				tx_busy: s.tx_st != TX_IDLE, hold_full: s.hold_v});
			ADDR_ERROR: rmux = 32'(error_reg_t'{rsvd: '0, pend: s.err_pend,
				code: s.err_code});
			default: rbad = 1'b1;
		endcase
		if (i_apb.psel && !s.armed) begin
			n.armed = 1'b1;
			n.rdata = rbad ? 32'h0 : rmux;
			n.slverr = rbad;
		end

		// Register writes and read side effects
		if (take) begin
			n.armed = 1'b0;
			if (i_apb.pwrite) begin
				unique case (i_apb.paddr)
					ADDR_MODEM: begin
						n.rs422 = wm.rs422;
						if (wm.rts > MODE_TRACK) begin
							err_set = 1'b1;
							err_val = ERR_ILLEGAL;
						end else begin
							n.rts_mode = wm.rts;
						end
						if (wm.dtr != s.dtr_mode) begin
							if (wm.dtr > MODE_TRACK) begin
								err_set = 1'b1;
								err_val = ERR_ILLEGAL;
							end else if (wm.rs422) begin
								err_set = 1'b1;
								err_val = ERR_CONFLICT;
							end else begin
								n.dtr_mode = wm.dtr;
							end
						end
					end
					ADDR_BAUD: begin
						if (bidx == BAUD_BAD || wb.rsvd != '0) begin
							err_set = 1'b1;
							err_val = ERR_ILLEGAL;
						end else begin
							n.baud_sel = bidx;
						end
					end
					ADDR_FORMAT: begin
						n.rx_software_pacing_enable = wf.rx_software_pacing_enable;
						n.tx_software_pacing_enable = wf.tx_software_pacing_enable;
						if (wf.wlen == WLEN_7 || wf.wlen == WLEN_8) begin
							n.word8 = (wf.wlen == WLEN_8);
						end else begin
							err_set = 1'b1;
							err_val = ERR_ILLEGAL;
						end
						if (wf.parity <= PAR_ONE) begin
							n.parity = wf.parity;
						end else begin
							err_set = 1'b1;
							err_val = ERR_ILLEGAL;
						end
						if (wf.stop == STOP_1 || wf.stop == STOP_2) begin
							n.stop2 = (wf.stop == STOP_2);
						end else begin
							err_set = 1'b1;
							err_val = ERR_ILLEGAL;
						end
					end
					ADDR_TXDATA: begin
						if (!s.hold_v) begin
							n.hold = i_apb.pwdata[7:0];
							n.hold_v = 1'b1;
						end
					end
					default: ;
				endcase
			end else begin
				unique case (i_apb.paddr)
					ADDR_RXDATA: begin
						n.rx_full = 1'b0;
						n.par_err = 1'b0;
					end
					ADDR_ERROR: n.err_pend = 1'b0;
					default: ;
				endcase
			end
		end
		if (err_set) begin
			n.err_code = err_val;
			n.err_pend = 1'b1;
		end

		// Transmitter
		if (s.tx_st != TX_IDLE) begin
			n.tx_cnt = tx_tick ? div - 20'h1 : s.tx_cnt - 20'h1;
		end
		unique case (s.tx_st)
			TX_IDLE: begin
				n.txd = 1'b1;
				if (hw_ok && s.flow_pend) begin
					tx_load = 1'b1;
					tx_word = s.flow_xon ? CHAR_XON : CHAR_XOFF;
					n.flow_pend = 1'b0;
				end else if (hw_ok && s.hold_v && !(s.tx_software_pacing_enable && s.paused)) begin
					tx_load = 1'b1;
					n.hold_v = 1'b0;
				end
				if (tx_load) begin
					n.tx_st = TX_START;
					n.txd = 1'b0;
					n.tx_sh = tx_word;
					n.tx_pbit = par_bit(s.parity, tx_word, s.word8);
					n.tx_cnt = div - 20'h1;
					n.tx_bit = 3'h0;
				end
			end
			TX_START: begin
				if (tx_tick) begin
					n.tx_st = TX_DATA;
					n.txd = s.tx_sh[0];
				end
			end
			TX_DATA: begin
				if (tx_tick) begin
					if (s.tx_bit == last_bit) begin
						if (s.parity != PAR_NONE) begin
							n.tx_st = TX_PAR;
							n.txd = s.tx_pbit;
						end else begin
							n.tx_st = TX_STOP;
							n.txd = 1'b1;
							n.tx_bit = s.stop2 ? 3'h1 : 3'h0;
						end
					end else begin
						n.tx_bit = s.tx_bit + 3'h1;
						n.tx_sh = s.tx_sh >> 1;
						n.txd = s.tx_sh[1];
					end
				end
			end
			TX_PAR: begin
				if (tx_tick) begin
					n.tx_st = TX_STOP;
					n.txd = 1'b1;
					n.tx_bit = s.stop2 ? 3'h1 : 3'h0;
				end
			end
			TX_STOP: begin
				if (tx_tick) begin
					if (s.tx_bit == 3'h0) begin
						n.tx_st = TX_IDLE;
					end else begin
						n.tx_bit = s.tx_bit - 3'h1;
					end
				end
			end
		endcase

		// Receiver
		if (s.rx_st != RX_IDLE) begin
			n.rx_cnt = rx_tick ? div - 20'h1 : s.rx_cnt - 20'h1;
		end
		unique case (s.rx_st)
			RX_IDLE: begin
				if (!rxd) begin
					n.rx_st = RX_START;
					n.rx_cnt = div >> 1;
					n.rx_pbad = 1'b0;
				end
			end
			RX_START: begin
				if (rx_tick) begin
					n.rx_st = rxd ? RX_IDLE : RX_DATA;
					n.rx_bit = 3'h0;
				end
			end
			RX_DATA: begin
				if (rx_tick) begin
					n.rx_sh = {rxd, s.rx_sh[7:1]};
					if (s.rx_bit == last_bit) begin
						n.rx_st = (s.parity != PAR_NONE) ? RX_PAR : RX_STOP;
						n.rx_bit = s.stop2 ? 3'h1 : 3'h0;
					end else begin
						n.rx_bit = s.rx_bit + 3'h1;
					end
				end
			end
			RX_PAR: begin
				if (rx_tick) begin
					n.rx_st = RX_STOP;
					n.rx_pbad = (rxd != par_bit(s.parity, rx_word, s.word8));
				end
			end
			RX_STOP: begin
				if (rx_tick) begin
					if (s.rx_bit == 3'h0) begin
						n.rx_st = RX_IDLE;
						if (s.rx_pbad) begin
							n.par_err = 1'b1;
						end
						if (s.tx_software_pacing_enable && rx_word == CHAR_XOFF) begin
							n.paused = 1'b1;
						end else if (s.tx_software_pacing_enable && rx_word == CHAR_XON) begin
							n.paused = 1'b0;
						end else if (n.rx_full == 1'b0) begin
							n.rx_buf = rx_word;
							n.rx_full = 1'b1;
						end
					end else begin
						n.rx_bit = s.rx_bit - 3'h1;
					end
				end
			end
		endcase

		// Receive pacing characters on readiness change
		n.ready_q = can_accept;
		if (s.rx_software_pacing_enable && can_accept != s.ready_q) begin
			n.flow_pend = 1'b1;
			n.flow_xon = can_accept;
		end

		// Reset leaves settings alone; power-on loads defaults
		if (i_rst || i_por) begin
			n.rxd_s = 2'h3;
			n.cts_s = 2'h0;
			n.dsr_s = 2'h0;
			n.dtr = 1'b0;
			n.rts = 1'b0;
			n.tx_st = TX_IDLE;
			n.tx_cnt = 20'h0;
			n.tx_bit = 3'h0;
			n.tx_sh = 8'h00;
			n.tx_pbit = 1'b0;
			n.txd = 1'b1;
			n.hold = 8'h00;
			n.hold_v = 1'b0;
			n.flow_pend = 1'b0;
			n.flow_xon = 1'b0;
			n.ready_q = 1'b1;
			n.paused = 1'b0;
			n.rx_st = RX_IDLE;
			n.rx_cnt = 20'h0;
			n.rx_bit = 3'h0;
			n.rx_sh = 8'h00;
			n.rx_pbad = 1'b0;
			n.rx_buf = 8'h00;
			n.rx_full = 1'b0;
			n.par_err = 1'b0;
			n.err_code = ERR_NONE;
			n.err_pend = 1'b0;
			n.armed = 1'b0;
			n.rdata = 32'h0;
			n.slverr = 1'b0;
		end
		if (i_por) begin
			n.dtr_mode = MODE_OFF;
			n.rts_mode = MODE_OFF;
			n.rs422 = 1'b0;
			n.baud_sel = BAUD_DEF_IDX;
			n.word8 = 1'b1;
			n.parity = PAR_NONE;
			n.stop2 = 1'b0;
			n.rx_software_pacing_enable = 1'b0;
			n.tx_software_pacing_enable = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register; settings untouched by i_rst
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_por || i_clk_en) begin
			s <= n;
		end
	end

	// Outputs
	assign o_txd = s.txd;
	assign o_dtr = s.dtr;
	assign o_rts = s.rts;
	// Bus answer: registered data, zero-wait ready gated by the enable
	assign o_apb = '{prdata: s.rdata,
		pready: i_apb.psel & i_apb.penable & s.armed & i_clk_en,
		pslverr: s.slverr};

endmodule
`default_nettype wire

/* logic/serial_line_pkg.sv */
`default_nettype none
package serial_line_pkg;
	// Device clock
	localparam int unsigned SYS_CLK_HZ = 40_000_000;
	// Register byte offsets
	localparam logic [7:0] ADDR_MODEM = 8'h00;
	localparam logic [7:0] ADDR_BAUD = 8'h04;
	localparam logic [7:0] ADDR_FORMAT = 8'h08;
	localparam logic [7:0] ADDR_TXDATA = 8'h0C;
	localparam logic [7:0] ADDR_RXDATA = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_ERROR = 8'h18;
	// Supported line rates
	localparam int BAUD_N = 17;
	localparam int unsigned BAUD_LIST [BAUD_N] = '{50, 75, 110, 150, 300, 1200, 1800,
		2000, 2400, 3600, 4800, 7200, 9600, 19200, 38400, 57600, 115200};
	localparam logic [4:0] BAUD_DEF_IDX = 5'h0C;
	localparam logic [4:0] BAUD_BAD = 5'h1F;
	// Modem line modes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ON = 2'h1;
	localparam logic [1:0] MODE_TRACK = 2'h2;
	// Parity types
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_EVEN = 3'h1;
	localparam logic [2:0] PAR_ODD = 3'h2;
	localparam logic [2:0] PAR_ZERO = 3'h3;
	localparam logic [2:0] PAR_ONE = 3'h4;
	// Legal word lengths and stop counts
	localparam logic [3:0] WLEN_7 = 4'h7;
	localparam logic [3:0] WLEN_8 = 4'h8;
	localparam logic [1:0] STOP_1 = 2'h1;
	localparam logic [1:0] STOP_2 = 2'h2;
	// Flow characters
	localparam logic [7:0] CHAR_XON = 8'h11;
	localparam logic [7:0] CHAR_XOFF = 8'h13;
	// Error codes, two's complement of -221 and -224
	localparam logic [15:0] ERR_CONFLICT = 16'hFF23;
	localparam logic [15:0] ERR_ILLEGAL = 16'hFF20;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	// Bus carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
	// Register layouts
	typedef struct packed {
		logic [26:0] rsvd;
		logic rs422;
		logic [1:0] rts;
		logic [1:0] dtr;
	} modem_reg_t;
	typedef struct packed {
		logic [14:0] rsvd;
		logic [16:0] rate;
	} baud_reg_t;
	typedef struct packed {
		logic [19:0] rsvd;
		logic tx_software_pacing_enable;
		logic rx_software_pacing_enable;
		logic [1:0] stop;
		logic pad;
		logic [2:0] parity;
		logic [3:0] wlen;
	} format_reg_t;
	typedef struct packed {
		logic [21:0] rsvd;
		logic valid;
		logic par_err;
		logic [7:0] data;
	} rxdata_reg_t;
	typedef struct packed {
		logic [24:0] rsvd;
		logic hw_block;
		logic paused;
		logic dsr;
		logic cts;
		logic rx_full;
		logic tx_busy;
		logic hold_full;
	} status_reg_t;
	typedef struct packed {
		logic [14:0] rsvd;
		logic pend;
		logic [15:0] code;
	} error_reg_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage
`default_nettype wire

/* tb/serial_line_checker.sv */
`default_nettype none
module serial_line_checker
	import serial_line_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_por,
	input wire logic i_clk_en,
	input wire apb_req_t i_apb,
	input wire apb_rsp_t o_apb,
	input wire logic o_txd,
	input wire logic o_dtr,
	input wire logic o_rts
);
	logic wr_t, rd_t;
	logic [1:0] dtr_m, rts_m, stop_m, settle;
	logic [16:0] rate_m;
	logic [3:0] wlen_m;
	logic [31:0] wd;
	////////////////////////////////////////////////////////////////
	// Transfers taken at this edge
	assign wr_t = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite;
	assign rd_t = i_apb.psel & i_apb.penable & o_apb.pready & !i_apb.pwrite;
	assign wd = i_apb.pwdata;
	function automatic logic listed(input logic [31:0] v);
		for (int i = 0; i < BAUD_N; i++) if (v == 32'(BAUD_LIST[i])) return 1'b1;
		return 1'b0;
	endfunction
	// Shadow of accepted settings, cleared only by power-on
	always_ff @(posedge i_sys_clk) begin
		if (i_por) begin
			dtr_m <= MODE_OFF;
			rts_m <= MODE_OFF;
			rate_m <= 17'h02580;
			wlen_m <= WLEN_8;
			stop_m <= STOP_1;
		end else if (wr_t) begin
			case (i_apb.paddr)
				ADDR_MODEM: begin
					if (wd[1:0] != 2'h3 && !(wd[4] && wd[1:0] != dtr_m)) dtr_m <= wd[1:0];
					if (wd[3:2] != 2'h3) rts_m <= wd[3:2];
				end
				ADDR_BAUD: if (wd[31:17] == 15'h0000 && listed(wd)) rate_m <= wd[16:0];
				ADDR_FORMAT: begin
					if (wd[3:0] == WLEN_7 || wd[3:0] == WLEN_8) wlen_m <= wd[3:0];
					if (wd[9:8] == STOP_1 || wd[9:8] == STOP_2) stop_m <= wd[9:8];
				end
				default: ;
			endcase
		end
	end
	// Cycles since the modem mode last moved
	always_ff @(posedge i_sys_clk) begin
		if (i_rst || i_por || (wr_t && i_apb.paddr == ADDR_MODEM)) settle <= 2'h0;
		else if (i_clk_en && settle != 2'h3) settle <= settle + 2'h1;
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst || i_por);
	dtr_level_a: assert property (settle == 2'h3 && dtr_m != MODE_TRACK |-> o_dtr == (dtr_m == MODE_ON))
		else $error("dtr level wrong");
	rts_level_a: assert property (settle == 2'h3 && rts_m != MODE_TRACK |-> o_rts == (rts_m == MODE_ON))
		else $error("rts level wrong");
	track_pair_a: assert property (settle == 2'h3 && dtr_m == MODE_TRACK && rts_m == MODE_TRACK |-> o_dtr == o_rts)
		else $error("tracking lines disagree");
	start_width_a: assert property ($fell(o_txd) |-> !o_txd[*8])
		else $error("low bit too short");
	modem_read_a: assert property (rd_t && i_apb.paddr == ADDR_MODEM |-> o_apb.prdata[3:0] == {rts_m, dtr_m})
		else $error("modem mode mismatch");
	baud_read_a: assert property (rd_t && i_apb.paddr == ADDR_BAUD |-> o_apb.prdata[16:0] == rate_m)
		else $error("baud rate mismatch");
	wlen_read_a: assert property (rd_t && i_apb.paddr == ADDR_FORMAT |-> o_apb.prdata[3:0] == wlen_m)
		else $error("word length mismatch");
	stop_read_a: assert property (rd_t && i_apb.paddr == ADDR_FORMAT |-> o_apb.prdata[9:8] == stop_m)
		else $error("stop count mismatch");
	cover property (wr_t && i_apb.paddr == ADDR_MODEM);
	cover property (rd_t && i_apb.paddr == ADDR_BAUD);
	cover property ($fell(o_txd));
endmodule

bind serial_line_ctrl serial_line_checker chk_i (
	.i_sys_clk(i_sys_clk),
	.i_rst(i_rst),
	.i_por(i_por),
	.i_clk_en(i_clk_en),
	.i_apb(i_apb),
	.o_apb(o_apb),
	.o_txd(o_txd),
	.o_dtr(o_dtr),
	.o_rts(o_rts)
);
`default_nettype wire

/* tb/serial_partner.sv */
`default_nettype none
module serial_partner
	import serial_line_pkg::*;
#(
	parameter int DIV = 10
) (
	input wire logic i_sys_clk,
	input wire logic i_txd,
	output var logic o_rxd,
	output var logic o_cts,
	output var logic o_dsr
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle line high, partner ready
	initial begin
		o_rxd = 1'b1;
		o_cts = 1'b1;
		o_dsr = 1'b1;
	end
	// Parity bit of an nb-bit word
	function automatic logic par(input logic [7:0] d, input int nb, input logic [2:0] pk);
		logic x;
		x = ^(d & ((nb == 7) ? 8'h7F : 8'hFF));
		case (pk)
			PAR_EVEN: return x;
			PAR_ODD: return ~x;
			PAR_ONE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	// Pause or release the device transmitter
	task automatic lines(input logic c, input logic s);
		o_cts <= c;
		o_dsr <= s;
	endtask
	// One frame, returns as the last stop bit begins
	task automatic send(input logic [7:0] d, input int nb, input logic [2:0] pk, input int sb,
		input logic bad);
		logic [11:0] f;
		int n;
		f = 12'hFFF;
		f[0] = 1'b0;
		for (int i = 0; i < nb; i++) f[i + 1] = d[i];
		n = nb + 1;
		if (pk != PAR_NONE) begin
			f[n] = par(d, nb, pk) ^ bad;
			n++;
		end
		n = n + sb;
		for (int i = 0; i < n; i++) begin
			o_rxd <= f[i];
			if (i < n - 1) repeat (DIV) @(posedge i_sys_clk);
		end
	endtask
	// Sample one device frame at mid-bit
	task automatic get(input int nb, input logic [2:0] pk, input int sb, output logic [7:0] d,
		output logic p, output logic ok);
		int n;
		n = 0;
		d = 8'h00;
		p = 1'b0;
		while (i_txd !== 1'b0 && n < 4000) begin
			@(posedge i_sys_clk);
			n++;
		end
		repeat (DIV / 2) @(posedge i_sys_clk);
		ok = (i_txd === 1'b0);
		for (int i = 0; i < nb; i++) begin
			repeat (DIV) @(posedge i_sys_clk);
			d[i] = i_txd;
		end
		if (pk != PAR_NONE) begin
			repeat (DIV) @(posedge i_sys_clk);
			p = i_txd;
		end
		for (int i = 0; i < sb; i++) begin
			repeat (DIV) @(posedge i_sys_clk);
			ok = ok & (i_txd === 1'b1);
		end
	endtask
endmodule
`default_nettype wire

/* tb/serial_port_line_control_tb.sv */
`default_nettype none
module serial_port_line_control_tb
	import serial_line_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DIV = 10;
	logic sys_clk, rst, por, ce, txd, dtr, rts, rxd, cts, dsr, e, ok, pb;
	apb_req_t req;
	apb_rsp_t rsp;
	logic [31:0] r;
	logic [7:0] d;
	int fail_count, n_tests, lows, nb, sb;
	////////////////////////////////////////////////////////////////
	serial_line_ctrl #(.CLK_HZ(1152000)) uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_por(por),
		.i_clk_en(ce), .i_apb(req), .o_apb(rsp), .i_rxd(rxd), .i_cts(cts), .i_dsr(dsr),
		.o_txd(txd), .o_dtr(dtr), .o_rts(rts));
	serial_partner #(.DIV(DIV)) pm (.i_sys_clk(sys_clk), .i_txd(txd), .o_rxd(rxd), .o_cts(cts),
		.o_dsr(dsr));
	// Clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		fail_count++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("tests=%0d errors=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	// One APB transfer, idle cycle first
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		// Ready and data as sampled at this rising edge; watchdog ends a hang
		do begin
			@(posedge sys_clk);
		end while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	function automatic logic [31:0] fmt(input logic [3:0] wl, input logic [2:0] p,
		input logic [1:0] st, input logic rp, input logic tp);
		return {20'h00000, tp, rp, st, 1'b0, p, wl};
	endfunction
	// Expect one device frame carrying c
	task automatic exp_tx(input logic [7:0] c, input logic [2:0] pk);
		pm.get(nb, pk, sb, d, pb, ok);
		chk({23'h0, ok, d}, {23'h1, c & ((nb == 7) ? 8'h7F : 8'hFF)});
		if (pk != PAR_NONE) chk({31'h0, pb}, {31'h0, pm.par(c, nb, pk)});
	endtask
	task automatic watch(input int cyc);
		lows = 0;
		repeat (cyc) begin
			@(posedge sys_clk);
			if (txd !== 1'b1) lows++;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		req = '0;
		ce = 1'b1;
		rst = 1'b1;
		por = 1'b1;
		fail_count = 0;
		n_tests = 0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		por <= 1'b0;
		// Power-on defaults and an unmapped address
		rd(ADDR_BAUD, 32'h0000_2580);
		rd(ADDR_FORMAT, fmt(WLEN_8, PAR_NONE, STOP_1, 1'b0, 1'b0));
		xfer(1'b0, 8'h1C, 32'h0);
		chk({r[30:0], e}, 32'h1);
		// Fixed levels, then tracking on both lines
		for (int m = 0; m < 3; m++) begin
			xfer(1'b1, ADDR_MODEM, 32'(m * 5));
			repeat (3) @(posedge sys_clk);
			chk({30'h0, dtr, rts}, (m == 0) ? 32'h0 : 32'h3);
		end
		// DTR change refused under RS422
		xfer(1'b1, ADDR_MODEM, 32'h19);
		rd(ADDR_MODEM, 32'h1A);
		rd(ADDR_ERROR, 32'h0001_FF23);
		xfer(1'b1, ADDR_MODEM, 32'h0A);
		// Unlisted rate refused, every listed rate kept
		xfer(1'b1, ADDR_BAUD, 32'h0000_2581);
		rd(ADDR_ERROR, 32'h0001_FF20);
		rd(ADDR_BAUD, 32'h0000_2580);
		for (int i = 0; i < BAUD_N; i++) begin
			xfer(1'b1, ADDR_BAUD, 32'(BAUD_LIST[i]));
			rd(ADDR_BAUD, 32'(BAUD_LIST[i]));
		end
		// Illegal mode codes refused, modes kept
		xfer(1'b1, ADDR_MODEM, 32'h0F);
		rd(ADDR_ERROR, 32'h0001_FF20);
		// Bad word length refused, other fields applied
		xfer(1'b1, ADDR_FORMAT, fmt(4'h9, PAR_ODD, STOP_2, 1'b0, 1'b0));
		rd(ADDR_ERROR, 32'h0001_FF20);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rd(ADDR_BAUD, 32'h0001_C200);
		rd(ADDR_FORMAT, fmt(WLEN_8, PAR_ODD, STOP_2, 1'b0, 1'b0));
		rd(ADDR_MODEM, 32'h0A);
		// Each parity type both ways
		for (int p = 0; p < 5; p++) begin
			nb = (p % 2) ? 7 : 8;
			sb = (p % 2) ? 2 : 1;
			xfer(1'b1, ADDR_FORMAT, fmt(4'(nb), 3'(p), 2'(sb), 1'b0, 1'b0));
			xfer(1'b1, ADDR_TXDATA, 32'h0000_00C5);
			exp_tx(8'hC5, 3'(p));
			for (int b = 0; b < 2; b++) if (p != 0 || b == 0) begin
				pm.send(8'hC5, nb, 3'(p), sb, b[0]);
				repeat (DIV) @(posedge sys_clk);
				rd(ADDR_RXDATA, {22'h0, 1'b1, b[0], (nb == 7) ? 8'h45 : 8'hC5});
			end
		end
		// CTS then DSR holds the transmitter
		nb = 8;
		sb = 1;
		xfer(1'b1, ADDR_FORMAT, fmt(WLEN_8, PAR_NONE, STOP_1, 1'b0, 1'b0));
		for (int k = 0; k < 2; k++) begin
			pm.lines(k[0], !k[0]);
			repeat (3) @(posedge sys_clk);
			xfer(1'b1, ADDR_TXDATA, 32'h0000_005A);
			watch(60);
			chk(32'(lows), 32'h0);
			pm.lines(1'b1, 1'b1);
			exp_tx(8'h5A, PAR_NONE);
		end
		// Receive pacing and buffer tracking
		xfer(1'b1, ADDR_FORMAT, fmt(WLEN_8, PAR_NONE, STOP_1, 1'b1, 1'b0));
		pm.send(8'hA5, 8, PAR_NONE, 1, 1'b0);
		exp_tx(CHAR_XOFF, PAR_NONE);
		chk({30'h0, dtr, rts}, 32'h0);
		rd(ADDR_RXDATA, 32'h0000_02A5);
		exp_tx(CHAR_XON, PAR_NONE);
		chk({30'h0, dtr, rts}, 32'h3);
		// Transmit pacing: Xoff halts data until Xon
		xfer(1'b1, ADDR_FORMAT, fmt(WLEN_8, PAR_NONE, STOP_1, 1'b0, 1'b1));
		pm.send(CHAR_XOFF, 8, PAR_NONE, 1, 1'b0);
		repeat (DIV) @(posedge sys_clk);
		xfer(1'b1, ADDR_TXDATA, 32'h0000_003C);
		watch(150);
		chk(32'(lows), 32'h0);
		pm.send(CHAR_XON, 8, PAR_NONE, 1, 1'b0);
		exp_tx(8'h3C, PAR_NONE);
		// Frozen block ignores a character on the line
		ce <= 1'b0;
		pm.send(8'h5A, 8, PAR_NONE, 1, 1'b0);
		repeat (DIV) @(posedge sys_clk);
		ce <= 1'b1;
		rd(ADDR_RXDATA, 32'h0000_00A5);
		print_verdict();
	end
endmodule
`default_nettype wire
